// file: logic/cmpref_channel.sv
// one comparator channel: control, mode, input select, sync and edge flags
`timescale 1ns/1ps
module cmpref_channel (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic wr_cn_i,
	input wire logic wr_md_i,
	input wire logic wr_mx_i,
	input wire logic [7:0] wdata_i,
	input wire logic cmp_result_i,
	output logic [7:0] cn_o,
	output logic [7:0] md_o,
	output logic [7:0] mx_o,
	output logic raw_out_o,
	output logic latched_o
);
	typedef struct packed {
		logic en;
		logic rif;
		logic fif;
		logic [1:0] hyp;
		logic [1:0] hyn;
		logic rie;
		logic fie;
		logic [1:0] resp;
		logic [1:0] psel;
		logic [1:0] nsel;
		logic s1;
		logic s2;
		logic prev;
	} cmpref_ch_st_t;

	cmpref_ch_st_t r;
	cmpref_ch_st_t n;
	logic rise;
	logic fall;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.s1 = cmp_result_i & r.en; // gated so a disabled channel idles low
		n.s2 = r.s1; // second synchroniser stage
		n.prev = r.s2;
		rise = r.s2 & ~r.prev; // edges seen on synced copy only
		fall = ~r.s2 & r.prev;
		if (wr_cn_i) begin
			n.en = wdata_i[cmpref_pkg::CN_EN];
			n.rif = wdata_i[cmpref_pkg::CN_RIF];
			n.fif = wdata_i[cmpref_pkg::CN_FIF];
			n.hyp = wdata_i[cmpref_pkg::CN_HYP +: 2];
			n.hyn = wdata_i[cmpref_pkg::CN_HYN +: 2];
		end
		if (wr_md_i) begin
			n.rie = wdata_i[cmpref_pkg::MD_RIE];
			n.fie = wdata_i[cmpref_pkg::MD_FIE];
			n.resp = wdata_i[cmpref_pkg::MD_RESP +: 2];
		end
		if (wr_mx_i) begin
			n.psel = wdata_i[cmpref_pkg::MX_POS +: 2];
			n.nsel = wdata_i[cmpref_pkg::MX_NEG +: 2];
		end
		// set after the write so a coinciding edge is kept
		n.rif = n.rif | rise;
		n.fif = n.fif | fall;
	end

	// state register
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.resp <= cmpref_pkg::RESP_RST;
		end else begin
			r <= n;
		end
	end

	// readback and outputs; raw path needs no clock
	assign raw_out_o = cmp_result_i & r.en;
	assign latched_o = r.s2;
	assign cn_o = {r.en, r.s2, r.rif, r.fif, r.hyp, r.hyn};
	assign md_o = {2'b00, r.rie, r.fie, 2'b00, r.resp};
	assign mx_o = {2'b00, r.nsel, 2'b00, r.psel};

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_rise_flag_set: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		(r.s2 && !r.prev) |=> r.rif) else $error("rise flag missed");
	a_fall_flag_set: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		(!r.s2 && r.prev) |=> r.fif) else $error("fall flag missed");
	a_flag_sticky: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		(r.rif && !wr_cn_i) |=> r.rif) else $error("rise flag lost");
	a_set_wins: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		(wr_cn_i && !wdata_i[cmpref_pkg::CN_FIF] && !r.s2 && r.prev)
		|=> r.fif) else $error("clear beat edge");
	a_sync_delay: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		r.s2 == $past(raw_out_o, 2)) else $error("sync delay wrong");
	a_off_low: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		!r.en |-> ##2 !latched_o) else $error("disabled out high");
endmodule : cmpref_channel

// file: logic/cmpref_pkg.sv
// register map, field positions and reset values for comparator/reference
package cmpref_pkg;
	// ------------------------------------------------------------
	// register addresses on the special-function register port
	// ------------------------------------------------------------
	localparam logic [1:0][7:0] ADDR_CN = {8'h9D, 8'h9A};
	localparam logic [1:0][7:0] ADDR_MD = {8'h9E, 8'h9B};
	localparam logic [1:0][7:0] ADDR_MX = {8'h9F, 8'h9C};
	localparam logic [7:0] ADDR_REF = 8'hD1;

	// ------------------------------------------------------------
	// comparator control fields
	// ------------------------------------------------------------
	localparam int CN_EN = 7;
	localparam int CN_OUT = 6;
	localparam int CN_RIF = 5;
	localparam int CN_FIF = 4;
	localparam int CN_HYP = 2;
	localparam int CN_HYN = 0;

	// ------------------------------------------------------------
	// mode and input select fields
	// ------------------------------------------------------------
	localparam int MD_RIE = 5;
	localparam int MD_FIE = 4;
	localparam int MD_RESP = 0;
	localparam int MX_POS = 0;
	localparam int MX_NEG = 4;

	// ------------------------------------------------------------
	// reference control fields
	// ------------------------------------------------------------
	localparam int REF_ZTC = 5;
	localparam int REF_LVL = 4;
	localparam int REF_SRC = 3;
	localparam int REF_TEMP = 2;
	localparam int REF_BIAS = 1;
	localparam int REF_BUF = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CN_RST = 8'h00;
	localparam logic [1:0] RESP_RST = 2'h2;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [5:0] REF_RST = 6'h00;
	localparam logic [7:0] RD_IDLE = 8'h00;

	// hysteresis codes
	typedef enum logic [1:0] {
		HYST_OFF = 2'h0,
		HYST_5MV = 2'h1,
		HYST_10MV = 2'h2,
		HYST_20MV = 2'h3
	} cmpref_hyst_t;
endpackage : cmpref_pkg

// file: logic/cmpref_top.sv
// comparator pair and reference control behind the register port
`timescale 1ns/1ps

module cmpref_top (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic [1:0] cmp_result_i,
	input wire logic adc_enable_i,
	output logic [1:0] cmp_power_o,
	output logic [1:0] cmp_raw_out_o,
	output logic [1:0] cmp_latched_out_o,
	output cmpref_pkg::cmpref_hyst_t [1:0] cmp_pos_hyst_o,
	output cmpref_pkg::cmpref_hyst_t [1:0] cmp_neg_hyst_o,
	output logic [1:0][1:0] cmp_response_o,
	output logic [1:0][1:0] cmp_pos_sel_o,
	output logic [1:0][1:0] cmp_neg_sel_o,
	output logic [1:0] cmp_irq_o,
	output logic cmp0_reset_src_o,
	output logic zero_tc_bias_force_o,
	output logic ref_level_select_o,
	output logic ref_source_select_o,
	output logic temp_sensor_on_o,
	output logic analog_bias_on_o,
	output logic ref_buffer_on_o,
	output logic vref_od_block_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0] refc;
		logic [7:0] rdata;
		logic [1:0] irq;
		logic od_block;
		logic rst_src;
	} cmpref_top_st_t;

	cmpref_top_st_t r;
	cmpref_top_st_t n;
	logic [1:0] rst_pipe_r;
	logic rst_n;
	logic [1:0] wr_cn;
	logic [1:0] wr_md;
	logic [1:0] wr_mx;
	logic [1:0][7:0] cn;
	logic [1:0][7:0] md;
	logic [1:0][7:0] mx;
	logic [1:0] latched;

	// address match, used for every write strobe and the read mux
	function automatic logic cmpref_hit(input logic [7:0] addr,
		input logic [7:0] target);
		cmpref_hit = (addr == target);
	endfunction : cmpref_hit

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	// assert at once, release two edges later so no flop sees a
	// release that lands right on a clock edge
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_pipe_r <= 2'b00;
		end else begin
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe_r[1];

	// ------------------------------------------------------------
	// comparator channels
	// ------------------------------------------------------------
	// both instances share one body; only the address differs
	for (genvar i = 0; i < 2; i++) begin : g_ch
		// write strobes per register
		assign wr_cn[i] = sfr_wr_i &
			cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_CN[i]);
		assign wr_md[i] = sfr_wr_i &
			cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_MD[i]);
		assign wr_mx[i] = sfr_wr_i &
			cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_MX[i]);

		cmpref_channel u_ch (
			.mclk_i(mclk_i),
			.rst_n_i(rst_n),
			.wr_cn_i(wr_cn[i]),
			.wr_md_i(wr_md[i]),
			.wr_mx_i(wr_mx[i]),
			.wdata_i(sfr_wdata_i),
			.cmp_result_i(cmp_result_i[i]),
			.cn_o(cn[i]),
			.md_o(md[i]),
			.mx_o(mx[i]),
			.raw_out_o(cmp_raw_out_o[i]),
			.latched_o(latched[i])
		);

		// analog controls straight from channel flops
		assign cmp_power_o[i] = cn[i][cmpref_pkg::CN_EN];
		assign cmp_latched_out_o[i] = latched[i];
		assign cmp_pos_hyst_o[i] =
			cmpref_pkg::cmpref_hyst_t'(cn[i][cmpref_pkg::CN_HYP +: 2]);
		assign cmp_neg_hyst_o[i] =
			cmpref_pkg::cmpref_hyst_t'(cn[i][cmpref_pkg::CN_HYN +: 2]);
		assign cmp_response_o[i] = md[i][cmpref_pkg::MD_RESP +: 2];
		assign cmp_pos_sel_o[i] = mx[i][cmpref_pkg::MX_POS +: 2];
		assign cmp_neg_sel_o[i] = mx[i][cmpref_pkg::MX_NEG +: 2];
	end

	// ------------------------------------------------------------
	// next state of reference, read data and requests
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		// only six bits are stored, top two are dropped
		if (sfr_wr_i && cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_REF)) begin
			n.refc = sfr_wdata_i[5:0]; // force-on bit writable
		end
		// read data is registered and idles at zero
		n.rdata = cmpref_pkg::RD_IDLE;
		if (sfr_rd_i) begin
			for (int k = 0; k < 2; k++) begin
				if (cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_CN[k])) begin
					n.rdata = cn[k];
				end
				if (cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_MD[k])) begin
					n.rdata = md[k];
				end
				if (cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_MX[k])) begin
					n.rdata = mx[k];
				end
			end
			if (cmpref_hit(sfr_addr_i, cmpref_pkg::ADDR_REF)) begin
				n.rdata = {2'b00, r.refc};
			end
		end
		// each enabled flag raises its channel request
		for (int k = 0; k < 2; k++) begin
			n.irq[k] = (cn[k][cmpref_pkg::CN_RIF] &
				md[k][cmpref_pkg::MD_RIE]) |
				(cn[k][cmpref_pkg::CN_FIF] &
				md[k][cmpref_pkg::MD_FIE]);
		end
		// supply reference with converter on leaves no open drain
		n.od_block = r.refc[cmpref_pkg::REF_SRC] & adc_enable_i;
		// only channel zero feeds the reset source path
		n.rst_src = cn[0][cmpref_pkg::CN_EN] & latched[0];
	end

	// state register; everything clears to zero
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.refc <= cmpref_pkg::REF_RST;
		end else begin
			r <= n;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sfr_rdata_o = r.rdata;
	assign cmp_irq_o = r.irq;
	assign cmp0_reset_src_o = r.rst_src;
	assign vref_od_block_o = r.od_block;
	// reference controls drive the analog block directly
	assign zero_tc_bias_force_o = r.refc[cmpref_pkg::REF_ZTC];
	assign ref_level_select_o = r.refc[cmpref_pkg::REF_LVL];
	assign ref_source_select_o = r.refc[cmpref_pkg::REF_SRC];
	assign temp_sensor_on_o = r.refc[cmpref_pkg::REF_TEMP];
	assign analog_bias_on_o = r.refc[cmpref_pkg::REF_BIAS];
	assign ref_buffer_on_o = r.refc[cmpref_pkg::REF_BUF];

	// ------------------------------------------------------------
	// checks: reference register
	// ------------------------------------------------------------
	a_ref_top_zero: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_rd_i && sfr_addr_i == cmpref_pkg::ADDR_REF)
		|=> sfr_rdata_o[7:6] == 2'b00) else $error("ref top bits set");
	a_ref_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_wr_i && sfr_addr_i == cmpref_pkg::ADDR_REF)
		|=> ref_source_select_o == $past(sfr_wdata_i[3])
		&& ref_buffer_on_o == $past(sfr_wdata_i[0]))
		else $error("ref write lost");
	a_ref_level: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_wr_i && sfr_addr_i == cmpref_pkg::ADDR_REF)
		|=> ref_level_select_o == $past(sfr_wdata_i[cmpref_pkg::REF_LVL]))
		else $error("ref level lost");
	a_ref_temp: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_wr_i && sfr_addr_i == cmpref_pkg::ADDR_REF)
		|=> temp_sensor_on_o == $past(sfr_wdata_i[cmpref_pkg::REF_TEMP]))
		else $error("sensor enable lost");
	a_ref_bias: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_wr_i && sfr_addr_i == cmpref_pkg::ADDR_REF)
		|=> analog_bias_on_o == $past(sfr_wdata_i[cmpref_pkg::REF_BIAS]))
		else $error("bias enable lost");
	// between writes the reference bits must not drift
	a_ref_hold: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		!(sfr_wr_i && sfr_addr_i == cmpref_pkg::ADDR_REF)
		|=> $stable(r.refc)) else $error("ref bits drifted");
	a_od_block: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(ref_source_select_o && adc_enable_i) |=> vref_od_block_o)
		else $error("open drain not blocked");
	a_od_clear: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		!(ref_source_select_o && adc_enable_i) |=> !vref_od_block_o)
		else $error("open drain blocked needlessly");

	// ------------------------------------------------------------
	// checks: comparator channels
	// ------------------------------------------------------------
	a_irq_rise: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(cn[0][cmpref_pkg::CN_RIF] && md[0][cmpref_pkg::MD_RIE])
		|=> cmp_irq_o[0]) else $error("rise request missing");
	a_irq_fall: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(cn[1][cmpref_pkg::CN_FIF] && md[1][cmpref_pkg::MD_FIE])
		|=> cmp_irq_o[1]) else $error("fall request missing");
	a_irq_quiet: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(!md[1][cmpref_pkg::MD_RIE] && !md[1][cmpref_pkg::MD_FIE])
		|=> !cmp_irq_o[1]) else $error("masked request raised");
	a_irq_mask0: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(!md[0][cmpref_pkg::MD_RIE] && !md[0][cmpref_pkg::MD_FIE])
		|=> !cmp_irq_o[0]) else $error("masked request raised");
	a_cn_readback: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_rd_i && sfr_addr_i == cmpref_pkg::ADDR_CN[0])
		|=> sfr_rdata_o[6] == $past(latched[0]))
		else $error("output state wrong");
	a_cn1_readback: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_rd_i && sfr_addr_i == cmpref_pkg::ADDR_CN[1])
		|=> sfr_rdata_o[6] == $past(latched[1]))
		else $error("output state wrong");
	a_md_unused: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_rd_i && sfr_addr_i == cmpref_pkg::ADDR_MD[0])
		|=> sfr_rdata_o[7:6] == 2'b00 && sfr_rdata_o[3:2] == 2'b00)
		else $error("mode unused bits set");
	a_mx_unused: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		(sfr_rd_i && sfr_addr_i == cmpref_pkg::ADDR_MX[1])
		|=> sfr_rdata_o[7:6] == 2'b00 && sfr_rdata_o[3:2] == 2'b00)
		else $error("select unused bits set");
	a_power_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		wr_cn[0] |=> cmp_power_o[0] == $past(sfr_wdata_i[cmpref_pkg::CN_EN]))
		else $error("enable write lost");
	a_hyst_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		wr_cn[1] |=> cmp_pos_hyst_o[1] == $past(sfr_wdata_i[3:2])
		&& cmp_neg_hyst_o[1] == $past(sfr_wdata_i[1:0]))
		else $error("hysteresis write lost");
	a_resp_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		wr_md[0] |=> cmp_response_o[0] == $past(sfr_wdata_i[1:0]))
		else $error("response write lost");
	a_sel_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		wr_mx[1] |=> cmp_pos_sel_o[1] == $past(sfr_wdata_i[1:0])
		&& cmp_neg_sel_o[1] == $past(sfr_wdata_i[5:4]))
		else $error("input select write lost");
	// raw pin idles low while powered down, latched pin two edges on
	a_raw_gated: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		!cmp_power_o[0] |-> !cmp_raw_out_o[0]) else $error("raw out high");
	a_latched_off: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		!cmp_power_o[1] |-> ##2 !cmp_latched_out_o[1])
		else $error("latched out high");
	a_rst_src: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		cmp0_reset_src_o == $past(cmp_power_o[0] && latched[0]))
		else $error("reset source wrong");
endmodule : cmpref_top

// file: tb/cmpref_pins.sv
// pin-side model: analog comparison results and pin watch
`timescale 1ns/1ps
module cmpref_pins (
	input wire logic mclk_i,
	input wire logic [1:0] level_i,
	input wire logic [1:0] raw_i,
	input wire logic [1:0] power_i,
	output logic [1:0] cmp_result_o,
	output logic pin_fault_o
);
	logic [1:0] level_q;
	initial begin
		cmp_result_o = 2'h0;
		pin_fault_o = 1'b0;
		level_q = 2'h0;
	end
	// level taken on the rising edge, shown on the falling one: a change
	// made at a falling edge reaches the design a fixed cycle later
	always @(posedge mclk_i) begin
		level_q <= level_i;
	end
	always @(negedge mclk_i) begin
		cmp_result_o <= level_q;
	end
	// a pin of an unpowered comparator must never show high
	always @(posedge mclk_i) begin
		pin_fault_o <= |(raw_i & ~power_i);
	end
endmodule : cmpref_pins

// file: tb/testbench.sv
// self-checking bench for the comparator pair and reference control
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if (8'(g) !== 8'(e)) begin \
		n_fail++; \
		$display("ERROR %s expected %0h seen %0h", nm, 8'(e), 8'(g)); \
	end \
end
module testbench;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic adc_en = 1'b0;
	logic [1:0] lvl = 2'h0;
	logic [7:0] rdata;
	logic [1:0] result, power, raw, latched, irq;
	cmpref_pkg::cmpref_hyst_t [1:0] pos_hyst, neg_hyst;
	logic [1:0][1:0] resp, pos_sel, neg_sel;
	logic rst_src, ztc, rlvl, rsrc, temp, bias, rbuf, od_block, pin_fault;
	logic [5:0] ref_bits;
	assign ref_bits = {ztc, rlvl, rsrc, temp, bias, rbuf};
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;
	int m_cn[2], m_md[2], m_mx[2], m_out[2];
	int d, hy;

	cmpref_top uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.sfr_addr_i(sfr_addr), .sfr_wdata_i(sfr_wdata), .sfr_wr_i(sfr_wr),
		.sfr_rd_i(sfr_rd), .sfr_rdata_o(rdata), .cmp_result_i(result),
		.adc_enable_i(adc_en), .cmp_power_o(power), .cmp_raw_out_o(raw),
		.cmp_latched_out_o(latched), .cmp_pos_hyst_o(pos_hyst),
		.cmp_neg_hyst_o(neg_hyst), .cmp_response_o(resp),
		.cmp_pos_sel_o(pos_sel), .cmp_neg_sel_o(neg_sel), .cmp_irq_o(irq),
		.cmp0_reset_src_o(rst_src), .zero_tc_bias_force_o(ztc),
		.ref_level_select_o(rlvl), .ref_source_select_o(rsrc),
		.temp_sensor_on_o(temp), .analog_bias_on_o(bias),
		.ref_buffer_on_o(rbuf), .vref_od_block_o(od_block));

	cmpref_pins pins (.mclk_i(mclk_i), .level_i(lvl), .raw_i(raw),
		.power_i(power), .cmp_result_o(result), .pin_fault_o(pin_fault));

	// ------------------------------------------------------------
	// clock, hang guard and closing report
	// ------------------------------------------------------------
	always #5 mclk_i = ~mclk_i;
	// a few hundred cycles are needed; the ceiling leaves wide margin
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			conclude();
		end
	end
	task conclude;
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// register port tasks and channel model
	// ------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(negedge mclk_i);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge mclk_i);
		sfr_wr = 1'b0;
	endtask : wr_reg
	// read data stands one cycle, so it is taken at the next falling edge
	task automatic rd_chk(input logic [7:0] a, input int e, input string nm);
		@(negedge mclk_i);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge mclk_i);
		sfr_rd = 1'b0;
		`CHK(nm, e, rdata)
	endtask : rd_chk
	// model output is the gated level; its transitions set sticky flags
	task automatic edge_upd(input int ch);
		int nw;
		nw = lvl[ch] & ((m_cn[ch] >> 7) & 1);
		if (nw == 1 && m_out[ch] == 0) m_cn[ch] |= 8'h20;
		if (nw == 0 && m_out[ch] == 1) m_cn[ch] |= 8'h10;
		m_out[ch] = nw;
	endtask : edge_upd
	task automatic wcn(input int ch, input int v);
		wr_reg(cmpref_pkg::ADDR_CN[ch], 8'(v));
		m_cn[ch] = v & 8'hBF;
		edge_upd(ch);
	endtask : wcn
	task automatic set_lvl(input int ch, input logic v);
		@(negedge mclk_i);
		lvl[ch] = v;
		edge_upd(ch);
	endtask : set_lvl
	task automatic chk_ch(input int ch);
		int e_irq;
		e_irq = ((m_cn[ch] & m_md[ch]) >> 4) & 3;
		repeat (6) @(negedge mclk_i);
		`CHK("raw", m_out[ch], raw[ch])
		`CHK("latched", m_out[ch], latched[ch])
		`CHK("power", (m_cn[ch] >> 7) & 1, power[ch])
		`CHK("pos_hyst", (m_cn[ch] >> 2) & 3, pos_hyst[ch])
		`CHK("neg_hyst", m_cn[ch] & 3, neg_hyst[ch])
		`CHK("irq", e_irq != 0, irq[ch])
		`CHK("response", m_md[ch] & 3, resp[ch])
		`CHK("pos_sel", m_mx[ch] & 3, pos_sel[ch])
		`CHK("neg_sel", (m_mx[ch] >> 4) & 3, neg_sel[ch])
		`CHK("pin_fault", 0, pin_fault)
		if (ch == 0) `CHK("reset_src", m_out[0], rst_src)
		rd_chk(cmpref_pkg::ADDR_CN[ch], m_cn[ch] | (m_out[ch] << 6),
			"control");
	endtask : chk_ch

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h68eb));
		repeat (3) @(negedge mclk_i);
		arst_n_i = 1'b1;
		repeat (6) @(negedge mclk_i);
		// reset values of every channel register, then a write to a hole, then the reference reset value
		for (int ch = 0; ch < 2; ch++) begin
			rd_chk(cmpref_pkg::ADDR_CN[ch], 8'h00, "cn_reset");
			rd_chk(cmpref_pkg::ADDR_MD[ch], 8'h02, "md_reset");
			rd_chk(cmpref_pkg::ADDR_MX[ch], 8'h00, "mx_reset");
		end
		wr_reg(8'h55, 8'hFF);
		rd_chk(8'h55, 8'h00, "unmapped");
		rd_chk(cmpref_pkg::ADDR_REF, 8'h00, "ref_reset");
		$display("test reset done");
		// reference bits to outputs, top bits never stick
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hFF : $urandom & 8'hFF;
			wr_reg(cmpref_pkg::ADDR_REF, 8'(d));
			@(negedge mclk_i);
			adc_en = 1'($urandom);
			repeat (3) @(negedge mclk_i);
			`CHK("ref_bits", d & 8'h3F, ref_bits)
			`CHK("od_block", ((d >> 3) & 1) & adc_en, od_block)
			rd_chk(cmpref_pkg::ADDR_REF, d & 8'h3F, "ref_read");
		end
		$display("test reference done");
		// identical channels: edges, sticky flags, gating, disable
		for (int ch = 0; ch < 2; ch++) begin
			d = ($urandom & 8'hCF) | 8'h20;
			wr_reg(cmpref_pkg::ADDR_MD[ch], 8'(d));
			m_md[ch] = d & 8'h33;
			rd_chk(cmpref_pkg::ADDR_MD[ch], m_md[ch], "mode");
			d = $urandom & 8'hFF;
			wr_reg(cmpref_pkg::ADDR_MX[ch], 8'(d));
			m_mx[ch] = d & 8'h33;
			hy = $urandom & 8'h0F;
			wcn(ch, 8'h80 | hy);
			chk_ch(ch);
			set_lvl(ch, 1'b1);
			chk_ch(ch);
			wcn(ch, m_cn[ch] & 8'hCF);
			chk_ch(ch);
			set_lvl(ch, 1'b0);
			chk_ch(ch);
			set_lvl(ch, 1'b1);
			chk_ch(ch);
			// clear lands on the very edge that sees the fall
			set_lvl(ch, 1'b0);
			repeat (2) @(negedge mclk_i);
			wcn(ch, m_cn[ch] & 8'hCF);
			m_cn[ch] |= 8'h10;
			chk_ch(ch);
			set_lvl(ch, 1'b1);
			chk_ch(ch);
			wcn(ch, hy);
			chk_ch(ch);
			set_lvl(ch, 1'b0);
			chk_ch(ch);
			$display("test channel %0d done", ch);
		end
		conclude();
	end
endmodule : testbench
